/* design/rxes_pkg.sv */
/*
  package for the receive elastic store: register indices, field positions,
  reset values and buffer geometry.
  assumes an apb slave with 32-bit data; printed offsets are word indices.
*/
// Summary of operation
// - slave and multiplexed modes pass receive bytes through a two-frame elastic buffer
// - write pointer advances on line side, read pointer on system receive clock
// - read frame alignment follows the system receive frame pulse
// - fast line data within two bytes of read pointer drops a frame
// - drop slip happens at frame boundary and sets slip direction to one
// - slow line data within two bytes of read pointer repeats the frame
// - repeat slip happens at next frame boundary and clears slip direction
// - each slip sets the event flag; interrupt low while flag and enable set
// - out of sync with trunk fill enabled, buffered output bytes become the trunk pattern; bypassed bytes pass unchanged
// - master mode bypasses the buffer unless payload loopback is active
package rxes_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] RXES_IDX_CFG   = 12'h07c;
  localparam logic [11:0] RXES_IDX_FLAGS = 12'h07d;
  localparam logic [11:0] RXES_IDX_TRUNK = 12'h07e;
  // ---------------------------------------------------------------
  // field positions of the configuration and flags registers, trunk pattern reset value
  // ---------------------------------------------------------------
  localparam int RXES_CFG_SLIP_DIR_BIT  = 0;
  localparam int RXES_CFG_SLIP_IE_BIT   = 1;
  localparam int RXES_CFG_TRUNK_EN_BIT  = 2;
  localparam int RXES_FLG_SLIP_BIT  = 0;
  localparam logic [7:0] RXES_TRUNK_RST = 8'hff;
  // ---------------------------------------------------------------
  // buffer geometry
  // ---------------------------------------------------------------
  localparam int RXES_FRAME_BYTES = 32;
  localparam int RXES_GUARD_BYTES = 2;
endpackage

/* design/rxes_store.sv */
/*
  receive elastic store with apb register file and slip interrupt.
  assumes line clock, system clock and frame pulse arrive asynchronously and
  are sampled by i_core_clk; line bytes are valid at each line byte strobe.
*/
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module rxes_store #(
  parameter int FRAME_BYTES = rxes_pkg::RXES_FRAME_BYTES
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [13:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // line side
  input  wire logic        i_line_clock,
  input  wire logic        i_line_byte_strobe,
  input  wire logic [7:0]  i_line_data,
  input  wire logic        i_line_frame_start,
  input  wire logic        i_in_sync,
  // system side
  input  wire logic        i_rx_system_clock,
  input  wire logic        i_rx_system_frame_pulse,
  // mode
  input  wire logic        i_clock_master_mode,
  input  wire logic        i_payload_loopback,
  // outputs
  output logic      [7:0]  o_rx_data,
  output logic             o_rx_data_valid,
  output logic             o_int_n
);
  localparam int DEPTH = 2 * FRAME_BYTES;
  localparam int AW    = $clog2(DEPTH);

  typedef struct packed {
    logic [2:0]    lclk_sy;
    logic [2:0]    sclk_sy;
    logic [1:0]    fp_sy;
    logic          fp_last;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic          slip_pending;
    logic          pend_dir;
    logic          slip_dir;
    logic          slip_flag;
    logic          slip_ie;
    logic          trk_en;
    logic [7:0]    trk_pat;
    logic [7:0]    data;
    logic          valid;
  } rxes_state_type;

  rxes_state_type st_r;
  rxes_state_type st_nxt;
  logic [7:0] mem_r [DEPTH];

  // distance from read to write pointer modulo the buffer
  function automatic logic [AW-1:0] rxes_dist(input logic [AW-1:0] a, input logic [AW-1:0] b);
    rxes_dist = a - b;
  endfunction

  // first slot of the frame half that holds the pointer
  function automatic logic [AW-1:0] rxes_frame_base(input logic [AW-1:0] p);
    rxes_frame_base = (p < AW'(FRAME_BYTES)) ? '0 : AW'(FRAME_BYTES);
  endfunction

  // nearest frame start at or after the pointer; a pointer already on a start stays,
  // so a frame pulse that agrees with the read side costs nothing
  function automatic logic [AW-1:0] rxes_align(input logic [AW-1:0] p);
    if (p == '0 || p == AW'(FRAME_BYTES))
      rxes_align = p;
    else
      rxes_align = (p < AW'(FRAME_BYTES)) ? AW'(FRAME_BYTES) : '0;
  endfunction

  logic [AW-1:0] fill;
  logic          line_edge;
  logic          sys_edge;
  logic          fp_rise;
  logic          use_buf;
  logic [11:0]   widx;
  logic          wr_acc;
  logic          rd_acc;
  logic          hit_flags;
  logic          at_boundary;
  logic [AW-1:0] rd_base;
  logic          slip_go;

  assign widx      = i_paddr[13:2];
  assign wr_acc    = i_psel & i_penable & i_pwrite;
  assign rd_acc    = i_psel & ~i_pwrite;
  assign hit_flags = widx == rxes_pkg::RXES_IDX_FLAGS;
  assign fill      = rxes_dist(st_r.wr_ptr, st_r.rd_ptr);
  // synchronised edges; first sync stage feeds only the second
  assign line_edge = st_r.lclk_sy[1] & ~st_r.lclk_sy[2];
  assign sys_edge  = st_r.sclk_sy[1] & ~st_r.sclk_sy[2];
  assign fp_rise   = st_r.fp_sy[1] & ~st_r.fp_last;
  assign use_buf   = ~i_clock_master_mode | i_payload_loopback;
  // the pulse edge still reads a byte, from the aligned frame start
  assign rd_base     = (fp_rise && use_buf) ? rxes_align(st_r.rd_ptr) : st_r.rd_ptr;
  assign at_boundary = (rd_base == AW'(FRAME_BYTES - 1)) || (rd_base == AW'(DEPTH - 1));
  assign slip_go     = sys_edge && use_buf && st_r.slip_pending && at_boundary;

  // ---------------------------------------------------------------
  // apb read data; zero-wait slave, unmapped reads zero, no error
  // ---------------------------------------------------------------
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  always_comb begin
    o_prdata = 32'h0000_0000;
    if (rd_acc) begin
      unique case (widx)
        rxes_pkg::RXES_IDX_CFG: begin
          o_prdata[rxes_pkg::RXES_CFG_SLIP_DIR_BIT] = st_r.slip_dir;
          o_prdata[rxes_pkg::RXES_CFG_SLIP_IE_BIT]  = st_r.slip_ie;
          o_prdata[rxes_pkg::RXES_CFG_TRUNK_EN_BIT] = st_r.trk_en;
        end
        rxes_pkg::RXES_IDX_FLAGS: o_prdata[rxes_pkg::RXES_FLG_SLIP_BIT] = st_r.slip_flag;
        rxes_pkg::RXES_IDX_TRUNK: o_prdata[7:0] = st_r.trk_pat;
        default: o_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic slip_now;
    slip_now = 1'b0;
    st_nxt = st_r;
    st_nxt.lclk_sy = {st_r.lclk_sy[1:0], i_line_clock};
    st_nxt.sclk_sy = {st_r.sclk_sy[1:0], i_rx_system_clock};
    st_nxt.fp_sy   = {st_r.fp_sy[0], i_rx_system_frame_pulse};
    st_nxt.fp_last = st_r.fp_sy[1];
    st_nxt.valid   = 1'b0;
    // line side writes; frame start realigns the write pointer to a frame
    if (line_edge && i_line_byte_strobe) begin
      if (i_line_frame_start)
        st_nxt.wr_ptr = rxes_frame_base(st_r.wr_ptr) + AW'(1);
      else
        st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + AW'(1);
    end
    // decide slip direction while the pointers are too close
    if (!st_r.slip_pending && use_buf) begin
      if (fill <= AW'(rxes_pkg::RXES_GUARD_BYTES) && fill != '0) begin
        st_nxt.slip_pending = 1'b1;
        st_nxt.pend_dir     = 1'b0;
      end else if (fill >= AW'(DEPTH - rxes_pkg::RXES_GUARD_BYTES)) begin
        st_nxt.slip_pending = 1'b1;
        st_nxt.pend_dir     = 1'b1;
      end
    end
    // read side: frame pulse realigns, each system clock edge reads a byte;
    // a pulse that skipped the read would starve the last slot and no slip could fire
    if (fp_rise && use_buf)
      st_nxt.rd_ptr = rd_base;
    if (sys_edge) begin
      st_nxt.valid = 1'b1;
      if (!use_buf)
        st_nxt.data = i_line_data;
      else begin
        st_nxt.data = mem_r[rd_base];
        if (st_r.slip_pending && at_boundary) begin
          slip_now = 1'b1;
          // drop: skip the next frame; repeat: rewind to this frame
          if (st_r.pend_dir)
            st_nxt.rd_ptr = rd_base + AW'(FRAME_BYTES + 1);
          else
            st_nxt.rd_ptr = rd_base - AW'(FRAME_BYTES - 1);
          st_nxt.slip_dir     = st_r.pend_dir;
          st_nxt.slip_pending = 1'b0;
        end else
          st_nxt.rd_ptr = (rd_base == AW'(DEPTH - 1)) ? '0 : rd_base + AW'(1);
      end
      if (use_buf && !i_in_sync && st_r.trk_en)
        st_nxt.data = st_r.trk_pat;
    end
    // registers; a slip in the clear cycle wins
    if (wr_acc) begin
      unique case (widx)
        rxes_pkg::RXES_IDX_CFG: begin
          st_nxt.slip_ie = i_pwdata[rxes_pkg::RXES_CFG_SLIP_IE_BIT];
          st_nxt.trk_en  = i_pwdata[rxes_pkg::RXES_CFG_TRUNK_EN_BIT];
        end
        rxes_pkg::RXES_IDX_TRUNK: st_nxt.trk_pat = i_pwdata[7:0];
        default: ;
      endcase
    end
    if (wr_acc && hit_flags && i_pwdata[rxes_pkg::RXES_FLG_SLIP_BIT])
      st_nxt.slip_flag = 1'b0;
    if (slip_now)
      st_nxt.slip_flag = 1'b1;
  end

  // ---------------------------------------------------------------
  // state register and buffer memory
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r         <= '0;
      st_r.trk_pat <= rxes_pkg::RXES_TRUNK_RST;
      st_r.rd_ptr  <= AW'(FRAME_BYTES);
    end else begin
      st_r <= st_nxt;
    end
  end

  // memory is not reset; it only holds payload
  always_ff @(posedge i_core_clk) begin
    if (line_edge && i_line_byte_strobe) begin
      mem_r[i_line_frame_start ? rxes_frame_base(st_r.wr_ptr) : st_r.wr_ptr] <= i_line_data;
    end
  end

  assign o_rx_data       = st_r.data;
  assign o_rx_data_valid = st_r.valid;
  assign o_int_n         = ~(st_r.slip_flag & st_r.slip_ie);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_slip_cycle;
    sys_edge && use_buf && !fp_rise && st_r.slip_pending && at_boundary;
  endsequence

  a_slip_sets_flag: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_slip_cycle |=> st_r.slip_flag) else $error("slip did not set flag");
  a_drop_dir_one: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_slip_cycle ##0 st_r.pend_dir |=> st_r.slip_dir) else $error("drop slip direction wrong");
  a_repeat_dir_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_slip_cycle ##0 !st_r.pend_dir |=> !st_r.slip_dir) else $error("repeat slip direction wrong");
  a_repeat_rewind: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_slip_cycle ##0 !st_r.pend_dir |=> st_r.rd_ptr == $past(st_r.rd_ptr) - AW'(FRAME_BYTES - 1))
    else $error("repeat slip did not rewind");
  a_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_int_n == !(st_r.slip_flag && st_r.slip_ie)) else $error("interrupt level wrong");
  a_flag_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    st_r.slip_flag && !(wr_acc && hit_flags && i_pwdata[0]) |=> st_r.slip_flag)
    else $error("slip flag lost without clear");
  a_trunk_fill: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    sys_edge && !fp_rise && use_buf && !i_in_sync && st_r.trk_en |=> o_rx_data == $past(st_r.trk_pat))
    else $error("trunk pattern not substituted");
  a_bypass_data: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    sys_edge && !use_buf |=> o_rx_data == $past(i_line_data) && o_rx_data_valid)
    else $error("bypass data wrong");
  a_frame_align: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    fp_rise && use_buf && !sys_edge |=> (st_r.rd_ptr == '0 || st_r.rd_ptr == AW'(FRAME_BYTES)))
    else $error("read not aligned to frame pulse");

  // ---------------------------------------------------------------
  // further checks on pointers, flags and output timing
  // ---------------------------------------------------------------
  sequence s_align_read;
    fp_rise && use_buf && sys_edge;
  endsequence

  // the pulse edge reads the first byte of a frame and moves one past it
  a_align_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_align_read |=> (st_r.rd_ptr == AW'(1) || st_r.rd_ptr == AW'(FRAME_BYTES + 1)))
    else $error("frame pulse read not at frame start");

  // a drop slip lands on the start of the frame after the skipped one
  a_drop_skip: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_slip_cycle ##0 st_r.pend_dir |=> st_r.rd_ptr == $past(st_r.rd_ptr) + AW'(FRAME_BYTES + 1))
    else $error("drop slip did not skip a frame");

  // pointers too close on the empty side arm a repeat
  a_guard_repeat: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    use_buf && !st_r.slip_pending && fill != '0 && fill <= AW'(rxes_pkg::RXES_GUARD_BYTES)
    |=> st_r.slip_pending && !st_r.pend_dir) else $error("repeat slip not armed");

  // pointers too close on the full side arm a drop
  a_guard_drop: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    use_buf && !st_r.slip_pending && fill >= AW'(DEPTH - rxes_pkg::RXES_GUARD_BYTES)
    |=> st_r.slip_pending && st_r.pend_dir) else $error("drop slip not armed");

  // a clear with no slip in the same cycle empties the flag
  a_clear_flag: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    wr_acc && hit_flags && i_pwdata[rxes_pkg::RXES_FLG_SLIP_BIT] && !slip_go |=> !st_r.slip_flag)
    else $error("slip flag not cleared");

  // with the buffer bypassed no slip can raise the flag
  a_bypass_no_slip: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !use_buf && !(wr_acc && hit_flags) |=> st_r.slip_flag == $past(st_r.slip_flag))
    else $error("slip flag moved in bypass");

  // one byte per system clock edge: valid is a single-cycle pulse
  a_valid_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_rx_data_valid |=> !o_rx_data_valid) else $error("valid longer than one cycle");

  // the output byte holds between system clock edges
  a_data_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !sys_edge |=> o_rx_data == $past(o_rx_data))
    else $error("output byte changed without a read");
endmodule

/* sim/rxes_sys_model.sv */
/*
  backplane model: drives the receive system clock and frame pulse.
  assumes the store samples both lines with its own core clock.
*/
`timescale 1ns/1ps
module rxes_sys_model #(
  parameter int FRAME_BYTES = 8
) (
  // control from the bench
  input  wire logic       i_run,
  input  wire logic [7:0] i_half_ns,
  // backplane outputs
  output logic            o_rx_system_clock,
  output logic            o_rx_system_frame_pulse
);
  int cnt;
  // clock stands low while stopped, so no stray reads happen between tests
  initial begin
    o_rx_system_clock = 1'b0;
    o_rx_system_frame_pulse = 1'b0;
    cnt = 0;
    forever begin
      #(i_half_ns);
      if (i_run || o_rx_system_clock) begin
        o_rx_system_clock = ~o_rx_system_clock;
        if (o_rx_system_clock) begin
          o_rx_system_frame_pulse = (cnt == 0);
          cnt = (cnt + 1) % FRAME_BYTES;
        end
      end
    end
  end
endmodule

/* sim/rxes_store_tb.sv */
/*
  self-checking bench for the receive elastic store.
  assumes zero-wait apb and the backplane model in rxes_sys_model.
*/
`timescale 1ns/1ps
module rxes_store_tb;
  localparam logic [31:0] DIRB = 32'h1 << rxes_pkg::RXES_CFG_SLIP_DIR_BIT;
  localparam logic [31:0] IRQB = 32'h1 << rxes_pkg::RXES_CFG_SLIP_IE_BIT;
  localparam logic [31:0] TRKB = 32'h1 << rxes_pkg::RXES_CFG_TRUNK_EN_BIT;
  logic i_core_clk = 1'b0, i_rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, line_clk = 1'b0, fstart = 1'b0, in_sync = 1'b1, master = 1'b0, loopb = 1'b0;
  logic [7:0] ldata = 8'h00, rx_data, half = 8'h64;
  logic [2:0] lc_cnt = 3'h0, bidx = 3'h0;
  logic sclk, sfp, rx_valid, int_n, run = 1'b0;
  int err_count = 0, checked = 0;
  always #10 i_core_clk = ~i_core_clk;
  // ----------------------------------------
  // line side: one byte per 160 ns, frame of eight bytes
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    lc_cnt <= lc_cnt + 3'h1;
    line_clk <= lc_cnt[2];
    if (lc_cnt == 3'h0) begin
      bidx <= bidx + 3'h1;
      ldata <= ldata + 8'h01;
      fstart <= (bidx == 3'h7);
    end
  end
  rxes_sys_model #(.FRAME_BYTES(8)) sys (.i_run(run), .i_half_ns(half), .o_rx_system_clock(sclk),
    .o_rx_system_frame_pulse(sfp));
  rxes_store #(.FRAME_BYTES(8)) dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_line_clock(line_clk), .i_line_byte_strobe(1'b1),
    .i_line_data(ldata), .i_line_frame_start(fstart), .i_in_sync(in_sync), .i_rx_system_clock(sclk),
    .i_rx_system_frame_pulse(sfp), .i_clock_master_mode(master), .i_payload_loopback(loopb),
    .o_rx_data(rx_data), .o_rx_data_valid(rx_valid), .o_int_n(int_n));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (n >= 50) begin
      err_count++;
      $display("CHECK FAILED at %0t: no pready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    apb(1'b1, idx, d, rd);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] rd;
    apb(1'b0, idx, 32'h0, rd);
    chk(rd & m, exp);
  endtask
  // bounded wait for the interrupt line to go low
  task automatic wait_int();
    int n;
    n = 0;
    while (int_n !== 1'b0 && n < 20000) begin
      @(posedge i_core_clk);
      n++;
    end
    chk({31'h0, int_n}, 32'h0);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1_900_000;
    err_count++;
    close_out();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(posedge i_core_clk);
    rdc(rxes_pkg::RXES_IDX_TRUNK, 32'hff, {24'h0, rxes_pkg::RXES_TRUNK_RST});
    rdc(rxes_pkg::RXES_IDX_FLAGS, 32'hffffffff, 32'h0);
    rdc(12'h07f, 32'hffffffff, 32'h0);
    wr(rxes_pkg::RXES_IDX_TRUNK, 32'h5a);
    rdc(rxes_pkg::RXES_IDX_TRUNK, 32'hff, 32'h5a);
    $display("test registers done");
    // line at 160 ns outruns a 200 ns system clock: frames are dropped
    run = 1'b1;
    wr(rxes_pkg::RXES_IDX_CFG, IRQB);
    wr(rxes_pkg::RXES_IDX_FLAGS, 32'h1);
    wait_int();
    rdc(rxes_pkg::RXES_IDX_CFG, DIRB, DIRB);
    repeat (50) @(posedge i_core_clk);
    rdc(rxes_pkg::RXES_IDX_FLAGS, 32'h1, 32'h1);
    wr(rxes_pkg::RXES_IDX_FLAGS, 32'h1);
    rdc(rxes_pkg::RXES_IDX_FLAGS, 32'h1, 32'h0);
    chk({31'h0, int_n}, 32'h1);
    wr(rxes_pkg::RXES_IDX_CFG, 32'h0);
    repeat (3000) @(posedge i_core_clk);
    chk({31'h0, int_n}, 32'h1);
    rdc(rxes_pkg::RXES_IDX_FLAGS, 32'h1, 32'h1);
    $display("test drop slip done");
    // a 140 ns system clock outruns the line: frames are repeated
    half = 8'h46;
    // let a drop still armed from the slow clock fire before the flag is cleared
    repeat (250) @(posedge i_core_clk);
    wr(rxes_pkg::RXES_IDX_CFG, IRQB);
    wr(rxes_pkg::RXES_IDX_FLAGS, 32'h1);
    wait_int();
    rdc(rxes_pkg::RXES_IDX_CFG, DIRB, 32'h0);
    $display("test repeat slip done");
    // out of sync with fill on: the next four bytes are the pattern
    in_sync <= 1'b0;
    wr(rxes_pkg::RXES_IDX_CFG, TRKB);
    repeat (4) begin
      do @(posedge i_core_clk); while (rx_valid !== 1'b1 && err_count < 1000);
      chk({24'h0, rx_data}, 32'h5a);
    end
    in_sync <= 1'b1;
    $display("test trunk fill done");
    // bypass in master mode: no slips until loopback keeps the buffer in
    master <= 1'b1;
    wr(rxes_pkg::RXES_IDX_CFG, IRQB);
    repeat (100) @(posedge i_core_clk);
    wr(rxes_pkg::RXES_IDX_FLAGS, 32'h1);
    repeat (3000) @(posedge i_core_clk);
    rdc(rxes_pkg::RXES_IDX_FLAGS, 32'h1, 32'h0);
    loopb <= 1'b1;
    wait_int();
    $display("test master mode done");
    close_out();
  end
endmodule
